// >>> src/gp8_map.svh
`ifndef GP8_MAP_SVH
`define GP8_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define GP8_ADDR_W 8
`define GP8_OFF_PINS 8'h00
`define GP8_OFF_LATCH 8'h04
`define GP8_OFF_DIR 8'h08
`define GP8_OFF_ANA 8'h0C
`define GP8_OFF_SET 8'h10
`define GP8_OFF_CLR 8'h14
`define GP8_OFF_OWNER 8'h18

// ----------------------------------------
// reset values and pin layout
// ----------------------------------------
`define GP8_LATCH_RST 8'h00
`define GP8_DIR_RST 8'hFF
`define GP8_ANA_RST 8'hFF
`define GP8_READ_NONE 8'h00
`define GP8_GPIO_ONLY 8'h9F
`define GP8_PIN_REG 5
`define GP8_PIN_CLK 6

`endif

// >>> src/gp8_pkg.sv
package gp8_pkg;

    typedef logic [7:0] gp8_byte_t;

    // output functions that can claim pin 6, highest first
    typedef struct packed {
        logic clkOutEn;
        logic clkOutVal;
        logic oscOutEn;
        logic oscOutVal;
    } gp8_pin6_fn_s;

    // pad drive: oeN low while the pin is driven
    typedef struct packed {
        gp8_byte_t out;
        gp8_byte_t oeN;
    } gp8_pad_s;

    // current owner of pin 6
    typedef enum logic [2:0] {
        GP8_SRC_GPIO = 3'b001,
        GP8_SRC_OSC = 3'b010,
        GP8_SRC_CLK = 3'b100
    } gp8_src_e;

endpackage

// >>> src/gp8_port.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "gp8_map.svh"

// How it works
// [RQ1] eight pins, each independently an input or an output.
// [RQ2] direction bit one turns the pin driver off; pin is an input.
// [RQ3] direction bit zero drives the pin from its output latch.
// [RQ4] data register reads pin levels; writes go to the latch.
// [RQ5] every port write samples pins, modifies, stores into the latch. Here only SET and CLR writes do; PINS and LATCH writes store the data as is.
// [RQ6] direction bits control drivers even for analog pins.
// [RQ7] software should keep analog pins set as inputs.
// [RQ8] analog-select one makes digital reads zero, enables analog input.
// [RQ9] analog select never changes digital output drive.
// [RQ10] all analog-select bits reset to analog mode.
// [RQ11] among enabled output functions the highest priority owns the pin.
// [RQ12] analog inputs live only in analog mode; outputs still obey priority.
// [RQ13] pin six: clock output, then oscillator, then general I/O.
// [RQ14] latch register reads the stored latch, not the pins.

module gp8_port (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [`GP8_ADDR_W-1:0] regAddr,
    input wire gp8_pkg::gp8_byte_t regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output gp8_pkg::gp8_byte_t regRdData,
    input wire gp8_pkg::gp8_byte_t padIn,
    output gp8_pkg::gp8_pad_s pad,
    input wire gp8_pkg::gp8_pin6_fn_s pin6Fn,
    input wire logic regCapEn,
    output gp8_pkg::gp8_byte_t analogEn
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    gp8_pkg::gp8_byte_t portOutputLatch;
    gp8_pkg::gp8_byte_t portDirection;
    gp8_pkg::gp8_byte_t portAnalogSelect;
    gp8_pkg::gp8_byte_t next_portOutputLatch;
    gp8_pkg::gp8_byte_t next_regRdData;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire logic hitPins;
    wire logic hitLatch;
    wire logic hitDir;
    wire logic hitAna;
    wire logic hitSet;
    wire logic hitClr;
    wire logic hitOwner;

    assign hitPins = (regAddr == `GP8_OFF_PINS);
    assign hitLatch = (regAddr == `GP8_OFF_LATCH);
    assign hitDir = (regAddr == `GP8_OFF_DIR);
    assign hitAna = (regAddr == `GP8_OFF_ANA);
    assign hitSet = (regAddr == `GP8_OFF_SET);
    assign hitClr = (regAddr == `GP8_OFF_CLR);
    assign hitOwner = (regAddr == `GP8_OFF_OWNER);

    // ----------------------------------------
    // digital input path
    // ----------------------------------------
    // analog pins read zero in every digital read, including the
    // read half of a read-modify-write, so a set/clear on a port with
    // analog pins can clear their latch bits: the hazard is kept as is
    wire gp8_pkg::gp8_byte_t pinRead;

    assign pinRead = padIn & ~portAnalogSelect; // RQ8
    assign analogEn = portAnalogSelect; // RQ12

    // ----------------------------------------
    // latch update
    // ----------------------------------------
    always_comb begin
        next_portOutputLatch = portOutputLatch;
        if (regWr) begin
            if (hitPins || hitLatch) begin
                next_portOutputLatch = regWrData; // RQ4
            end else if (hitSet) begin
                next_portOutputLatch = pinRead | regWrData; // RQ5
            end else if (hitClr) begin
                next_portOutputLatch = pinRead & ~regWrData; // RQ5
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            portOutputLatch <= `GP8_LATCH_RST;
        end else begin
            portOutputLatch <= next_portOutputLatch;
        end
    end

    // ----------------------------------------
    // direction and analog select
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            portDirection <= `GP8_DIR_RST;
            portAnalogSelect <= `GP8_ANA_RST; // RQ10
        end else begin
            if (regWr && hitDir) begin
                portDirection <= regWrData;
            end
            if (regWr && hitAna) begin
                portAnalogSelect <= regWrData;
            end
        end
    end

    // ----------------------------------------
    // pin 6 owner
    // ----------------------------------------
    gp8_pkg::gp8_src_e pin6Owner;
    wire logic pin6Out;
    wire logic pin6OeN;

    assign pin6Owner = pin6Fn.clkOutEn ? gp8_pkg::GP8_SRC_CLK
        : pin6Fn.oscOutEn ? gp8_pkg::GP8_SRC_OSC
        : gp8_pkg::GP8_SRC_GPIO; // RQ11 RQ13
    // a peripheral that owns pin six drives it whatever its direction bit says
    assign pin6Out = (pin6Owner == gp8_pkg::GP8_SRC_CLK) ? pin6Fn.clkOutVal
        : (pin6Owner == gp8_pkg::GP8_SRC_OSC) ? pin6Fn.oscOutVal
        : portOutputLatch[`GP8_PIN_CLK]; // RQ3 RQ13
    assign pin6OeN = (pin6Owner == gp8_pkg::GP8_SRC_GPIO) ? portDirection[`GP8_PIN_CLK] : 1'b0; // RQ2 RQ11

    // ----------------------------------------
    // pad drivers, one per pin
    // ----------------------------------------
    // analog select is deliberately absent here: it only shapes reads
    genvar p;
    generate
        for (p = 0; p < 8; p++) begin : g_pin
            if (p == `GP8_PIN_CLK) begin : g_fn
                assign pad.out[p] = pin6Out; // RQ13
                assign pad.oeN[p] = pin6OeN; // RQ11
            end else if (p == `GP8_PIN_REG) begin : g_reg
                // regulator capacitor takes the pin and silences the driver
                assign pad.out[p] = portOutputLatch[p];
                assign pad.oeN[p] = regCapEn | portDirection[p]; // RQ11
            end else begin : g_io
                assign pad.out[p] = portOutputLatch[p]; // RQ3 RQ9
                assign pad.oeN[p] = portDirection[p]; // RQ1 RQ2 RQ6
            end
        end
    endgenerate

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        next_regRdData = `GP8_READ_NONE;
        if (hitPins) begin
            next_regRdData = pinRead; // RQ4 RQ8
        end else if (hitLatch) begin
            next_regRdData = portOutputLatch; // RQ14
        end else if (hitDir) begin
            next_regRdData = portDirection;
        end else if (hitAna) begin
            next_regRdData = portAnalogSelect;
        end else if (hitOwner) begin
            next_regRdData = {5'h00, pin6Owner};
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= `GP8_READ_NONE;
        end else if (regRd) begin
            regRdData <= next_regRdData;
        end else begin
            regRdData <= `GP8_READ_NONE;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    input_hiz_a: assert property ( // RQ2
        ((portDirection & `GP8_GPIO_ONLY) & ~pad.oeN) == 8'h00
    ) else $error("input pin is being driven");

    output_drive_a: assert property ( // RQ3
        (regWr && hitDir) |=> ((~portDirection & `GP8_GPIO_ONLY & pad.oeN) == 8'h00)
            && (((pad.out ^ portOutputLatch) & `GP8_GPIO_ONLY) == 8'h00)
    ) else $error("output pin not driven from latch");

    pin_read_a: assert property ( // RQ4
        (regRd && hitPins) |=> regRdData == $past(padIn & ~portAnalogSelect)
    ) else $error("port read does not show pin levels");

    rmw_set_a: assert property ( // RQ5
        (regWr && hitSet) |=> portOutputLatch == $past(pinRead | regWrData)
    ) else $error("set write did not merge with pin levels");

    rmw_clear_a: assert property ( // RQ5
        (regWr && hitClr) |=> portOutputLatch == $past(pinRead & ~regWrData)
    ) else $error("clear write did not merge with pin levels");

    analog_zero_a: assert property ( // RQ8
        (regRd && hitPins && portAnalogSelect == 8'hFF) |=> regRdData == 8'h00
    ) else $error("analog pins read nonzero");

    analog_output_a: assert property ( // RQ9
        (portAnalogSelect == 8'hFF && portDirection == 8'h00 && !regCapEn
            && !pin6Fn.clkOutEn && !pin6Fn.oscOutEn)
            |-> pad.oeN == 8'h00 && pad.out == portOutputLatch
    ) else $error("analog select blocked digital output");

    reset_analog_a: assert property ( // RQ10
        !$past(rst_n) |-> portAnalogSelect == 8'hFF && analogEn == 8'hFF
    ) else $error("analog select not set after reset");

    analog_fn_a: assert property ( // RQ12
        (regWr && hitAna) |=> analogEn == $past(regWrData)
    ) else $error("analog enable does not follow select");

    pin6_prio_a: assert property ( // RQ11 RQ13
        pin6Fn.clkOutEn |-> !pad.oeN[6] && pad.out[6] == pin6Fn.clkOutVal
    ) else $error("clock output lost pin six");

    pin6_osc_a: assert property ( // RQ13
        (!pin6Fn.clkOutEn && pin6Fn.oscOutEn)
            |-> !pad.oeN[6] && pad.out[6] == pin6Fn.oscOutVal
    ) else $error("oscillator output lost pin six");

    latch_read_a: assert property ( // RQ14
        (regWr && hitLatch) ##1 (regRd && hitLatch) |=> regRdData == $past(regWrData, 2)
    ) else $error("latch read does not return stored value");

    // ----------------------------------------
    // pin ownership and register upkeep
    // ----------------------------------------
    gpio_follow_a: assert property ( // RQ1 RQ3
        (((pad.out ^ portOutputLatch) | (pad.oeN ^ portDirection)) & `GP8_GPIO_ONLY) == 8'h00
    ) else $error("general pin not following latch and direction");

    reg_cap_a: assert property ( // RQ11
        regCapEn |-> pad.oeN[`GP8_PIN_REG]
    ) else $error("pin five driven while regulator owns it");

    pin5_gpio_a: assert property ( // RQ2 RQ3
        !regCapEn |-> pad.oeN[`GP8_PIN_REG] == portDirection[`GP8_PIN_REG]
            && pad.out[`GP8_PIN_REG] == portOutputLatch[`GP8_PIN_REG]
    ) else $error("pin five not under general control");

    pin6_gpio_a: assert property ( // RQ13
        (!pin6Fn.clkOutEn && !pin6Fn.oscOutEn)
            |-> pad.oeN[`GP8_PIN_CLK] == portDirection[`GP8_PIN_CLK]
            && pad.out[`GP8_PIN_CLK] == portOutputLatch[`GP8_PIN_CLK]
    ) else $error("pin six not returned to general control");

    owner_onehot_a: assert property ( // RQ11
        $onehot(pin6Owner)
    ) else $error("pin six has no single owner");

    owner_read_a: assert property ( // RQ13
        (regRd && hitOwner) |=> regRdData == $past({5'h00, pin6Fn.clkOutEn,
            !pin6Fn.clkOutEn && pin6Fn.oscOutEn, !pin6Fn.clkOutEn && !pin6Fn.oscOutEn})
    ) else $error("owner read does not match pin six owner");

    // only the analog select moved, so nothing on the pads may move
    ana_no_drive_a: assert property ( // RQ6 RQ9
        (regWr && hitAna) ##1 ($stable(regCapEn) && $stable(pin6Fn)) |-> pad == $past(pad)
    ) else $error("analog select changed the pin drive");

    analog_read_a: assert property ( // RQ8
        (regRd && hitPins) |=> (regRdData & $past(portAnalogSelect)) == 8'h00
    ) else $error("analog pin read as one");

    latch_write_a: assert property ( // RQ4
        (regWr && (hitPins || hitLatch)) |=> portOutputLatch == $past(regWrData)
    ) else $error("port write did not reach the latch");

    // registers move only on their own write
    latch_hold_a: assert property ( // RQ4
        !(regWr && (hitPins || hitLatch || hitSet || hitClr)) |=> $stable(portOutputLatch)
    ) else $error("latch changed without a write");

    dir_write_a: assert property ( // RQ2 RQ3
        (regWr && hitDir) |=> portDirection == $past(regWrData)
    ) else $error("direction write lost");

    dir_hold_a: assert property ( // RQ2
        !(regWr && hitDir) |=> $stable(portDirection)
    ) else $error("direction changed without a write");

    ana_hold_a: assert property ( // RQ10
        !(regWr && hitAna) |=> $stable(portAnalogSelect)
    ) else $error("analog select changed without a write");

    rd_idle_a: assert property ( // RQ4
        !regRd |=> regRdData == `GP8_READ_NONE
    ) else $error("read data stands beyond its cycle");

    unmapped_rd_a: assert property ( // RQ4
        (regRd && !(hitPins || hitLatch || hitDir || hitAna || hitOwner)) |=> regRdData == `GP8_READ_NONE
    ) else $error("unmapped read returned data");

endmodule // gp8_port

// >>> verification/gp8_pins_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// outside world seen by the eight pins
// ----------------------------------------
module gp8_pins_model (
    input wire logic sys_clk,
    input wire gp8_pkg::gp8_pad_s pad,
    input wire gp8_pkg::gp8_byte_t extVal,
    input wire gp8_pkg::gp8_byte_t extEn,
    output gp8_pkg::gp8_byte_t padIn
);
    // undriven pins wander every cycle so a stale level never passes for data
    gp8_pkg::gp8_byte_t floatLvl = 8'h00;
    always_ff @(posedge sys_clk) begin
        floatLvl <= ~floatLvl;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            padIn[i] = !pad.oeN[i] ? pad.out[i] : (extEn[i] ? extVal[i] : floatLvl[i]);
        end
    end
endmodule // gp8_pins_model

// >>> verification/eight_bit_gpio_port_bench.sv
`timescale 1ns/1ps
`include "gp8_map.svh"

module eight_bit_gpio_port_bench;
    // ----------------------------------------
    // stimulus and instances
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    gp8_pkg::gp8_byte_t regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    gp8_pkg::gp8_byte_t regRdData, padIn, analogEn;
    gp8_pkg::gp8_pad_s pad;
    gp8_pkg::gp8_pin6_fn_s pin6Fn = 4'h0;
    logic regCapEn = 1'b0;
    gp8_pkg::gp8_byte_t extVal = 8'h00;
    gp8_pkg::gp8_byte_t extEn = 8'h00;
    int n_errors = 0;
    int num_checks = 0;

    gp8_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .padIn(padIn), .pad(pad), .pin6Fn(pin6Fn), .regCapEn(regCapEn),
        .analogEn(analogEn));
    gp8_pins_model pins_u (.sys_clk(sys_clk), .pad(pad), .extVal(extVal), .extEn(extEn), .padIn(padIn));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= addr;
        regWrData <= data;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input string what, input logic [7:0] addr, input logic [7:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= addr;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        check(what, exp, regRdData);
    endtask

    task automatic drive_ext(input logic [7:0] val, input logic [7:0] en);
        @(posedge sys_clk);
        extVal <= val;
        extEn <= en;
        #1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        drive_ext(8'h5A, 8'hFF);
        check("oeN", 8'hFF, pad.oeN);
        check("analogEn", 8'hFF, analogEn);
        rd("pins", `GP8_OFF_PINS, 8'h00);
        rd("latch", `GP8_OFF_LATCH, 8'h00);
        rd("dir", `GP8_OFF_DIR, 8'hFF);
        rd("ana", `GP8_OFF_ANA, 8'hFF);
        rd("unmapped", 8'h1C, 8'h00);
        @(posedge sys_clk);
        #1;
        check("rd idle", 8'h00, regRdData);
    endtask

    task automatic t_input;
        drive_ext(8'hA5, 8'hFF);
        wr(`GP8_OFF_ANA, 8'h00);
        rd("pins", `GP8_OFF_PINS, 8'hA5);
        wr(`GP8_OFF_ANA, 8'h0F);
        check("analogEn", 8'h0F, analogEn);
        rd("pins ana", `GP8_OFF_PINS, 8'hA0);
        wr(`GP8_OFF_PINS, 8'h3C);
        check("oeN", 8'hFF, pad.oeN);
        rd("latch", `GP8_OFF_LATCH, 8'h3C);
        rd("pins", `GP8_OFF_PINS, 8'hA0);
    endtask

    task automatic t_output;
        drive_ext(8'h00, 8'h00);
        wr(`GP8_OFF_DIR, 8'h00);
        wr(`GP8_OFF_PINS, 8'h96);
        check("oeN", 8'h00, pad.oeN);
        check("out", 8'h96, pad.out);
        wr(`GP8_OFF_ANA, 8'hFF);
        check("out ana", 8'h96, pad.out);
        check("oeN ana", 8'h00, pad.oeN);
        rd("latch", `GP8_OFF_LATCH, 8'h96);
        rd("pins ana", `GP8_OFF_PINS, 8'h00);
        wr(`GP8_OFF_ANA, 8'h00);
        rd("pins", `GP8_OFF_PINS, 8'h96);
        @(posedge sys_clk);
        regCapEn <= 1'b1;
        #1;
        check("oeN cap", 8'h20, pad.oeN);
        @(posedge sys_clk);
        regCapEn <= 1'b0;
        wr(`GP8_OFF_DIR, 8'hFF);
    endtask

    // upper nibble comes from outside, lower nibble from the latch
    task automatic t_rmw;
        drive_ext(8'h50, 8'hF0);
        wr(`GP8_OFF_DIR, 8'hF0);
        wr(`GP8_OFF_PINS, 8'h05);
        wr(`GP8_OFF_SET, 8'h02);
        rd("latch set", `GP8_OFF_LATCH, 8'h57);
        wr(`GP8_OFF_CLR, 8'h01);
        rd("latch clr", `GP8_OFF_LATCH, 8'h56);
        rd("set reg", `GP8_OFF_SET, 8'h00);
        wr(`GP8_OFF_ANA, 8'h04);
        wr(`GP8_OFF_SET, 8'h00);
        rd("latch ana", `GP8_OFF_LATCH, 8'h52);
        wr(`GP8_OFF_DIR, 8'hFF);
    endtask

    task automatic t_pin6;
        logic [3:0] fn [4] = '{4'hE, 4'h3, 4'h9, 4'h0};
        logic [2:0] own [4] = '{3'b100, 3'b010, 3'b100, 3'b001};
        wr(`GP8_OFF_ANA, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            pin6Fn <= fn[i];
            rd("owner", `GP8_OFF_OWNER, {5'h00, own[i]});
            check("oeN6", {7'h00, ~(fn[i][3] | fn[i][1])}, {7'h00, pad.oeN[6]});
            if (fn[i][3] | fn[i][1]) begin
                check("out6", {7'h00, fn[i][3] ? fn[i][2] : fn[i][0]}, {7'h00, pad.out[6]});
            end
        end
    endtask

    // latch write and latch read with no idle cycle between the strobes
    task automatic t_latch_b2b;
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= `GP8_OFF_LATCH;
        regWrData <= 8'hC3;
        @(posedge sys_clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        check("latch b2b", 8'hC3, regRdData);
        check("out b2b", 8'hC3, pad.out);
        check("oeN b2b", 8'hFF, pad.oeN);
    endtask

    // second reset in mid-run brings every register back
    task automatic t_rerst;
        wr(`GP8_OFF_ANA, 8'h00);
        wr(`GP8_OFF_DIR, 8'h00);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        check("oeN rst", 8'hFF, pad.oeN);
        check("out rst", 8'h00, pad.out);
        check("analogEn rst", 8'hFF, analogEn);
        rd("ana rst", `GP8_OFF_ANA, 8'hFF);
        rd("dir rst", `GP8_OFF_DIR, 8'hFF);
        rd("latch rst", `GP8_OFF_LATCH, 8'h00);
    endtask

    // ----------------------------------------
    // run and verdict
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_input();
        t_output();
        t_rmw();
        t_pin6();
        t_latch_b2b();
        t_rerst();
        end_of_test();
    end

    // a hang counts as a mismatch
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
endmodule // eight_bit_gpio_port_bench
